/* File: design/sfc_cmd_engine.v */
`timescale 1ns/1ns
`include "sfc_map.vh"

module sfc_cmd_engine #(
  parameter        ADDR_W      = 19,
  parameter        FIFO_DEPTH  = 8,
  parameter [31:0] PROG_CYC    = `SFC_PROGRAM_TIME_CYC,
  parameter [31:0] SECTOR_CYC  = `SFC_SECTOR_ERASE_TIME_CYC,
  parameter [31:0] BLOCK_CYC   = `SFC_BLOCK_ERASE_TIME_CYC,
  parameter [31:0] FULL_CYC    = `SFC_FULL_ERASE_TIME_CYC
) (
  input  wire              core_clk,           // Core clock
  input  wire              sys_rst,            // Synchronous reset
  input  wire              sel_n,              // Select pin, active low
  input  wire              sclk,               // Serial clock pin
  input  wire              dual_line_zero_i,   // Data line zero in
  output reg               dual_line_zero_o_q, // Data line zero out
  output reg               dual_line_zero_oe_q, // Data line zero drive
  input  wire              dual_line_one_i,    // Data line one in
  output reg               dual_line_one_o_q,  // Data line one out
  output reg               dual_line_one_oe_q, // Data line one drive
  output reg  [ADDR_W-1:0] mem_rd_addr_q,      // Array read address
  input  wire [7:0]        mem_rd_data,        // Array read data
  output wire              mem_wr_valid,       // Program word valid
  input  wire              mem_wr_ready,       // Array takes word
  output wire [ADDR_W-1:0] mem_wr_addr,        // Program address
  output wire [7:0]        mem_wr_data,        // Program byte
  output reg               mem_erase_q,        // Erase start pulse
  output reg  [1:0]        mem_erase_kind_q,   // Sector, block or chip
  output reg  [ADDR_W-1:0] mem_erase_addr_q,   // Erase base address
  output reg  [7:0]        status_q            // Live status byte
);

  // Link states
  localparam [9:0] L_IDLE  = 10'h001;
  localparam [9:0] L_CMD   = 10'h002;
  localparam [9:0] L_ADDR  = 10'h004;
  localparam [9:0] L_DUMMY = 10'h008;
  localparam [9:0] L_RDATA = 10'h010;
  localparam [9:0] L_SDATA = 10'h020;
  localparam [9:0] L_PDATA = 10'h040;
  localparam [9:0] L_WSR   = 10'h080;
  localparam [9:0] L_END   = 10'h100;
  localparam [9:0] L_IGN   = 10'h200;
  // Operation states
  localparam [2:0] O_IDLE  = 3'h1;
  localparam [2:0] O_DRAIN = 3'h2;
  localparam [2:0] O_WAIT  = 3'h4;

  // Protected-region test from the protection bits
  function prot_hit;
    input [ADDR_W-1:0] a;
    input [3:0]        p;
    reg   [ADDR_W-1:0] span;
    begin
      span = {{(ADDR_W-1){1'b0}}, 1'b1} << (ADDR_W - 4 + p[1:0]);
      if (p[2]) begin
        prot_hit = 1'b1;
      end else if (p[1:0] == 2'h0) begin
        prot_hit = 1'b0;
      end else if (p[3]) begin
        prot_hit = (a < span);
      end else begin
        prot_hit = (a >= (~span + {{(ADDR_W-1){1'b0}}, 1'b1}));
      end
    end
  endfunction

  reg  [2:0]        sclk_s_q;
  reg  [2:0]        sel_s_q;
  reg  [1:0]        d0_s_q;
  reg  [1:0]        d1_s_q;
  reg  [9:0]        st_q;
  reg  [2:0]        op_q;
  reg  [4:0]        cnt_q;
  reg  [7:0]        sh_q;
  reg  [7:0]        opc_q;
  reg               dual_q;
  reg  [23:0]       addr_q;
  reg  [7:0]        wsr_q;
  reg               wel_q;
  reg               busy_q;
  reg  [3:0]        prot_q;
  reg               lock_q;
  reg  [ADDR_W-1:0] pg_base_q;
  reg  [7:0]        pg_col_q;
  reg  [8:0]        pg_cnt_q;
  reg  [7:0]        dr_col_q;
  reg  [8:0]        dr_left_q;
  reg  [31:0]       tmr_q;
  reg  [7:0]        page_mem [0:255];
  wire              sclk_rise;
  wire              sclk_fall;
  wire              sel_rise;
  wire              sel_fall;
  wire              frame;
  wire [7:0]        in_byte;
  wire [23:0]       addr_nx;
  wire              addr_last;
  wire              is_read;
  wire              pg_we;
  wire              fifo_in_ready;
  wire [ADDR_W-1:0] tgt;
  wire [ADDR_W-1-`SFC_SECTOR_LSB:0] sector_index;
  wire [ADDR_W-1-`SFC_BLOCK_LSB:0]  block_index;

  // Edges of the synchronised pins
  assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
  assign sel_rise  = sel_s_q[1] & ~sel_s_q[2];
  assign sel_fall  = ~sel_s_q[1] & sel_s_q[2];
  assign frame     = ~sel_s_q[1];

  // Sampled bits, MSB first
  assign in_byte   = {sh_q[6:0], d0_s_q[1]};
  assign addr_nx   = dual_q ? {addr_q[21:0], d1_s_q[1], d0_s_q[1]}
                            : {addr_q[22:0], d0_s_q[1]};
  assign addr_last = (cnt_q == (dual_q ? `SFC_DUAL_ADDR_LAST : `SFC_SINGLE_ADDR_LAST));
  assign is_read   = (opc_q == `SFC_OP_DUAL_READ) | (opc_q == `SFC_OP_DUAL_IO);
  assign pg_we     = frame & ~sel_fall & sclk_rise & (st_q == L_PDATA) & (cnt_q == `SFC_BYTE_LAST);
  assign tgt          = addr_q[ADDR_W-1:0];
  assign sector_index = tgt[ADDR_W-1:`SFC_SECTOR_LSB];
  assign block_index  = tgt[ADDR_W-1:`SFC_BLOCK_LSB];

  // Two-flop synchronisers for the link pins
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sclk_s_q <= 3'h0;
      sel_s_q  <= 3'h7;
      d0_s_q   <= 2'h0;
      d1_s_q   <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk};
      sel_s_q  <= {sel_s_q[1:0], sel_n};
      d0_s_q   <= {d0_s_q[0], dual_line_zero_i};
      d1_s_q   <= {d1_s_q[0], dual_line_one_i};
    end
  end

  // Page buffer; column wraps in the page, later bytes overwrite older
  always @(posedge core_clk) begin
    if (pg_we) begin
      page_mem[pg_col_q] <= in_byte;
    end
  end

  // Link decoder, commit on select rise, and self-timed operations
  always @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= L_IDLE;
      op_q <= O_IDLE;
      cnt_q <= 5'h00;
      sh_q <= 8'h00;
      opc_q <= 8'h00;
      dual_q <= 1'b0;
      addr_q <= 24'h000000;
      wsr_q <= 8'h00;
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      prot_q <= `SFC_PROT_RST;
      lock_q <= `SFC_LOCK_RST;
      pg_base_q <= {ADDR_W{1'b0}};
      pg_col_q <= 8'h00;
      pg_cnt_q <= 9'h000;
      dr_col_q <= 8'h00;
      dr_left_q <= 9'h000;
      tmr_q <= 32'h00000000;
      mem_rd_addr_q <= {ADDR_W{1'b0}};
      mem_erase_q <= 1'b0;
      mem_erase_kind_q <= 2'h0;
      mem_erase_addr_q <= {ADDR_W{1'b0}};
      dual_line_zero_o_q <= 1'b0;
      dual_line_zero_oe_q <= 1'b0;
      dual_line_one_o_q <= 1'b0;
      dual_line_one_oe_q <= 1'b0;
    end else begin
      mem_erase_q <= 1'b0;
      if (sel_rise) begin
        // End of frame: release lines, commit only complete write commands
        st_q <= L_IDLE;
        dual_line_zero_oe_q <= 1'b0;
        dual_line_one_oe_q <= 1'b0;
        if (st_q == L_END) begin
          case (opc_q)
            `SFC_OP_WRITE_UNLOCK: begin
              wel_q <= 1'b1;
            end
            `SFC_OP_WRITE_LOCK: begin
              wel_q <= 1'b0;
            end
            `SFC_OP_STATUS_WRITE: begin
              if (wel_q) begin
                prot_q <= wsr_q[`SFC_ST_PROT_MSB:`SFC_ST_PROT_LSB];
                lock_q <= wsr_q[`SFC_ST_LOCK];
              end
              wel_q <= 1'b0;
            end
            `SFC_OP_CHIP_ERASE_A, `SFC_OP_CHIP_ERASE_B: begin
              if (wel_q && prot_q[2:0] == 3'h0) begin
                mem_erase_q <= 1'b1;
                mem_erase_kind_q <= `SFC_KIND_CHIP;
                mem_erase_addr_q <= {ADDR_W{1'b0}};
                tmr_q <= FULL_CYC;
                busy_q <= 1'b1;
                op_q <= O_WAIT;
              end else begin
                wel_q <= 1'b0;
              end
            end
            `SFC_OP_SECTOR_ERASE_A, `SFC_OP_SECTOR_ERASE_B: begin
              if (wel_q && !prot_hit(tgt, prot_q)) begin
                mem_erase_q <= 1'b1;
                mem_erase_kind_q <= `SFC_KIND_SECTOR;
                mem_erase_addr_q <= {sector_index, {`SFC_SECTOR_LSB{1'b0}}};
                tmr_q <= SECTOR_CYC;
                busy_q <= 1'b1;
                op_q <= O_WAIT;
              end else begin
                wel_q <= 1'b0;
              end
            end
            `SFC_OP_BLOCK_ERASE: begin
              if (wel_q && !prot_hit(tgt, prot_q)) begin
                mem_erase_q <= 1'b1;
                mem_erase_kind_q <= `SFC_KIND_BLOCK;
                mem_erase_addr_q <= {block_index, {`SFC_BLOCK_LSB{1'b0}}};
                tmr_q <= BLOCK_CYC;
                busy_q <= 1'b1;
                op_q <= O_WAIT;
              end else begin
                wel_q <= 1'b0;
              end
            end
            default: begin
              wel_q <= wel_q;
            end
          endcase
        end else if (st_q == L_PDATA) begin
          // Whole bytes only; a partial last byte never reached the buffer
          if (wel_q && pg_cnt_q != 9'h000 && !prot_hit(pg_base_q, prot_q)) begin
            dr_col_q <= pg_base_q[7:0];
            dr_left_q <= pg_cnt_q;
            busy_q <= 1'b1;
            op_q <= O_DRAIN;
          end else if (wel_q) begin
            wel_q <= 1'b0;
          end
        end
      end else if (sel_fall) begin
        st_q <= L_CMD;
        cnt_q <= 5'h00;
        dual_q <= 1'b0;
      end else if (frame && sclk_rise) begin
        // Rising serial clock: sample opcode, address and data
        case (st_q)
          L_CMD: begin
            sh_q <= in_byte;
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == `SFC_BYTE_LAST) begin
              cnt_q <= 5'h00;
              opc_q <= in_byte;
              if (busy_q && in_byte != `SFC_OP_STATUS_READ) begin
                st_q <= L_IGN;
              end else begin
                case (in_byte)
                  `SFC_OP_DUAL_READ, `SFC_OP_PROGRAM, `SFC_OP_SECTOR_ERASE_A,
                  `SFC_OP_SECTOR_ERASE_B, `SFC_OP_BLOCK_ERASE: begin
                    st_q <= L_ADDR;
                  end
                  `SFC_OP_DUAL_IO: begin
                    st_q <= L_ADDR;
                    dual_q <= 1'b1;
                  end
                  `SFC_OP_STATUS_READ: begin
                    st_q <= L_SDATA;
                  end
                  `SFC_OP_STATUS_WRITE: begin
                    st_q <= L_WSR;
                  end
                  `SFC_OP_WRITE_UNLOCK, `SFC_OP_WRITE_LOCK,
                  `SFC_OP_CHIP_ERASE_A, `SFC_OP_CHIP_ERASE_B: begin
                    st_q <= L_END;
                  end
                  default: begin
                    st_q <= L_IGN;
                  end
                endcase
              end
            end
          end
          L_ADDR: begin
            addr_q <= addr_nx;
            cnt_q <= cnt_q + 5'h01;
            if (addr_last) begin
              cnt_q <= 5'h00;
              mem_rd_addr_q <= addr_nx[ADDR_W-1:0];
              pg_base_q <= addr_nx[ADDR_W-1:0];
              pg_col_q <= addr_nx[7:0];
              pg_cnt_q <= 9'h000;
              if (is_read) begin
                st_q <= L_DUMMY;
              end else if (opc_q == `SFC_OP_PROGRAM) begin
                st_q <= L_PDATA;
              end else begin
                st_q <= L_END;
              end
            end
          end
          L_DUMMY: begin
            // Dummy values ignored; byte of eight clocks or dual cycle of four
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == (dual_q ? `SFC_DUAL_DUMMY_LAST : `SFC_SINGLE_DUMMY_LAST)) begin
              cnt_q <= 5'h00;
              st_q <= L_RDATA;
            end
          end
          L_PDATA: begin
            sh_q <= in_byte;
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == `SFC_BYTE_LAST) begin
              cnt_q <= 5'h00;
              pg_col_q <= pg_col_q + 8'h01;
              if (pg_cnt_q != 9'h100) begin
                pg_cnt_q <= pg_cnt_q + 9'h001;
              end
            end
          end
          L_WSR: begin
            sh_q <= in_byte;
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == `SFC_BYTE_LAST) begin
              cnt_q <= 5'h00;
              wsr_q <= in_byte;
              st_q <= L_END;
            end
          end
          L_END: begin
            st_q <= L_IGN;
          end
          default: begin
            st_q <= st_q;
          end
        endcase
      end else if (frame && sclk_fall) begin
        // Falling serial clock: shift data out
        if (st_q == L_RDATA) begin
          dual_line_zero_oe_q <= 1'b1;
          dual_line_one_oe_q <= 1'b1;
          cnt_q <= (cnt_q == `SFC_PAIR_LAST) ? 5'h00 : cnt_q + 5'h01;
          if (cnt_q == 5'h00) begin
            dual_line_one_o_q <= mem_rd_data[7];
            dual_line_zero_o_q <= mem_rd_data[6];
            sh_q <= {mem_rd_data[5:0], 2'h0};
            mem_rd_addr_q <= mem_rd_addr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
          end else begin
            dual_line_one_o_q <= sh_q[7];
            dual_line_zero_o_q <= sh_q[6];
            sh_q <= {sh_q[5:0], 2'h0};
          end
        end else if (st_q == L_SDATA) begin
          dual_line_one_oe_q <= 1'b1;
          cnt_q <= (cnt_q == `SFC_BYTE_LAST) ? 5'h00 : cnt_q + 5'h01;
          if (cnt_q == 5'h00) begin
            dual_line_one_o_q <= status_q[7];
            sh_q <= {status_q[6:0], 1'b0};
          end else begin
            dual_line_one_o_q <= sh_q[7];
            sh_q <= {sh_q[6:0], 1'b0};
          end
        end
      end
      // Self-timed operation: drain page into the FIFO, then wait
      case (op_q)
        O_IDLE: begin
          // No assignment here, so a start made above in this cycle survives
        end
        O_DRAIN: begin
          if (fifo_in_ready) begin
            dr_col_q <= dr_col_q + 8'h01;
            dr_left_q <= dr_left_q - 9'h001;
            if (dr_left_q == 9'h001) begin
              tmr_q <= PROG_CYC;
              op_q <= O_WAIT;
            end
          end
        end
        O_WAIT: begin
          tmr_q <= tmr_q - 32'h00000001;
          if (tmr_q <= 32'h00000001) begin
            busy_q <= 1'b0;
            wel_q <= 1'b0;
            op_q <= O_IDLE;
          end
        end
        default: begin
          op_q <= O_IDLE;
        end
      endcase
    end
  end

  // Status byte image
  always @(posedge core_clk) begin
    if (sys_rst) begin
      status_q <= 8'h00;
    end else begin
      status_q <= {lock_q, 1'b0, prot_q, wel_q, busy_q};
    end
  end

  // Program words toward the array
  sfc_fifo #(
    .WIDTH (ADDR_W + 8),
    .DEPTH (FIFO_DEPTH),
    .PTR_W (3)
  ) u_fifo (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .in_valid    (op_q == O_DRAIN),
    .in_ready    (fifo_in_ready),
    .in_data     ({pg_base_q[ADDR_W-1:8], dr_col_q, page_mem[dr_col_q]}),
    .out_valid_q (mem_wr_valid),
    .out_ready   (mem_wr_ready),
    .out_data_q  ({mem_wr_addr, mem_wr_data})
  );

endmodule // sfc_cmd_engine

/* File: design/sfc_fifo.v */
`timescale 1ns/1ns

module sfc_fifo #(
  parameter WIDTH = 27,
  parameter DEPTH = 8,
  parameter PTR_W = 3
) (
  input  wire             core_clk,    // Core clock
  input  wire             sys_rst,     // Synchronous reset
  input  wire             in_valid,    // Write side valid
  output wire             in_ready,    // Room for one more word
  input  wire [WIDTH-1:0] in_data,     // Write side word
  output reg              out_valid_q, // Read side valid
  input  wire             out_ready,   // Read side accepts
  output reg  [WIDTH-1:0] out_data_q   // Read side word
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_q;
  reg [PTR_W-1:0] rd_ptr_q;
  reg [PTR_W:0]   count_q;
  wire            push;
  wire            load;

  // Handshake terms
  assign in_ready = (count_q != DEPTH[PTR_W:0]);
  assign push     = in_valid & in_ready;
  assign load     = (count_q != {(PTR_W+1){1'b0}}) & (~out_valid_q | out_ready);

  // Storage write
  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // Pointers, count and registered output stage
  always @(posedge core_clk) begin
    if (sys_rst) begin
      wr_ptr_q    <= {PTR_W{1'b0}};
      rd_ptr_q    <= {PTR_W{1'b0}};
      count_q     <= {(PTR_W+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data_q  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
      end
      if (load) begin
        out_data_q  <= mem[rd_ptr_q];
        out_valid_q <= 1'b1;
        rd_ptr_q    <= rd_ptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
      if (push & ~load) begin
        count_q <= count_q + {{PTR_W{1'b0}}, 1'b1};
      end else if (load & ~push) begin
        count_q <= count_q - {{PTR_W{1'b0}}, 1'b1};
      end
    end
  end

endmodule // sfc_fifo

/* File: design/sfc_map.vh */
`ifndef SFC_MAP_VH
`define SFC_MAP_VH

// Instruction opcodes
`define SFC_OP_DUAL_READ      8'h3B
`define SFC_OP_DUAL_IO        8'hBB
`define SFC_OP_PROGRAM        8'h02
`define SFC_OP_SECTOR_ERASE_A 8'h20
`define SFC_OP_SECTOR_ERASE_B 8'hD7
`define SFC_OP_BLOCK_ERASE    8'hD8
`define SFC_OP_CHIP_ERASE_A   8'h60
`define SFC_OP_CHIP_ERASE_B   8'hC7
`define SFC_OP_STATUS_READ    8'h05
`define SFC_OP_STATUS_WRITE   8'h01
`define SFC_OP_WRITE_UNLOCK   8'h06
`define SFC_OP_WRITE_LOCK     8'h04

// Status byte layout and reset values
`define SFC_ST_BUSY       0
`define SFC_ST_WEL        1
`define SFC_ST_PROT_LSB   2
`define SFC_ST_PROT_MSB   5
`define SFC_ST_LOCK       7
`define SFC_PROT_RST      4'h0
`define SFC_LOCK_RST      1'h0

// Last bit-count values of each phase (count starts at zero)
`define SFC_BYTE_LAST         5'h07
`define SFC_SINGLE_ADDR_LAST  5'h17
`define SFC_DUAL_ADDR_LAST    5'h0B
`define SFC_SINGLE_DUMMY_LAST 5'h07
`define SFC_DUAL_DUMMY_LAST   5'h03
`define SFC_PAIR_LAST         5'h03

// Erase kinds on the memory port
`define SFC_KIND_SECTOR 2'h1
`define SFC_KIND_BLOCK  2'h2
`define SFC_KIND_CHIP   2'h3
`define SFC_SECTOR_LSB  12
`define SFC_BLOCK_LSB   16

// Self-timed operation times in microseconds, and cycle counts
`define SFC_CLK_MHZ                125
`define SFC_PROGRAM_TIME_US        1000
`define SFC_SECTOR_ERASE_TIME_US   2000
`define SFC_BLOCK_ERASE_TIME_US    4000
`define SFC_FULL_ERASE_TIME_US     8000
`define SFC_PROGRAM_TIME_CYC       (`SFC_PROGRAM_TIME_US * `SFC_CLK_MHZ)
`define SFC_SECTOR_ERASE_TIME_CYC  (`SFC_SECTOR_ERASE_TIME_US * `SFC_CLK_MHZ)
`define SFC_BLOCK_ERASE_TIME_CYC   (`SFC_BLOCK_ERASE_TIME_US * `SFC_CLK_MHZ)
`define SFC_FULL_ERASE_TIME_CYC    (`SFC_FULL_ERASE_TIME_US * `SFC_CLK_MHZ)

`endif

/* File: test/sfc_cmd_engine_chk.sv */
`timescale 1ns/1ns
module sfc_cmd_engine_chk #(parameter ADDR_W = 19) (
  input wire              core_clk,            // Core clock
  input wire              sys_rst,             // Reset
  input wire              sel_n,               // Select
  input wire              dual_line_zero_oe_q, // Line zero drive
  input wire              dual_line_one_oe_q,  // Line one drive
  input wire              mem_wr_valid,        // Write valid
  input wire              mem_wr_ready,        // Write ready
  input wire [ADDR_W-1:0] mem_wr_addr,         // Write address
  input wire [7:0]        mem_wr_data,         // Write byte
  input wire              mem_erase_q,         // Erase pulse
  input wire [1:0]        mem_erase_kind_q,    // Erase kind
  input wire [ADDR_W-1:0] mem_erase_addr_q,    // Erase base
  input wire [7:0]        status_q             // Status byte
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  oe_idle_a: assert property (sel_n [*8] |-> !dual_line_zero_oe_q && !dual_line_one_oe_q)
    else $error("line driven while deselected");
  oe_pair_a: assert property (dual_line_zero_oe_q |-> dual_line_one_oe_q)
    else $error("line zero driven alone");
  erase_busy_a: assert property (mem_erase_q |-> ##[0:2] status_q[0])
    else $error("erase without busy");
  sector_base_a: assert property (mem_erase_q && mem_erase_kind_q == 2'h1 |-> mem_erase_addr_q[11:0] == 12'h000)
    else $error("sector base not aligned");
  block_base_a: assert property (mem_erase_q && mem_erase_kind_q == 2'h2 |-> mem_erase_addr_q[15:0] == 16'h0000)
    else $error("block base not aligned");
  chip_gate_a: assert property (mem_erase_q && mem_erase_kind_q == 2'h3 |-> status_q[4:2] == 3'h0)
    else $error("chip erase while protected");
  erase_wel_a: assert property (mem_erase_q |-> $past(status_q[1], 2))
    else $error("erase without latch");
  wr_hold_a: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data))
    else $error("program word dropped");
  wel_done_a: assert property ($fell(status_q[0]) |-> ##[0:1] !status_q[1])
    else $error("latch kept after write");
  erase_c: cover property (mem_erase_q);
  wr_c: cover property (mem_wr_valid && mem_wr_ready);
  dual_c: cover property (dual_line_zero_oe_q);
endmodule // sfc_cmd_engine_chk

/* File: test/sfc_cmd_engine_test.sv */
`timescale 1ns/1ns
module sfc_cmd_engine_test;
  reg         core_clk, sys_rst, sel_n, sclk;
  reg  [1:0]  h, q;
  reg  [7:0]  b;
  wire        o0, e0, o1, e1, wv, wr, ee;
  wire [18:0] ra, wa, ea;
  wire [7:0]  rd, wd, st;
  wire [1:0]  ek;
  integer     miscompares = 0, num_checks = 0, k;
  integer     ne = 0;
  // Count erase start pulses
  always @(posedge core_clk) if (ee) ne <= ne + 1;
  // Wire levels: device drive wins, else host pattern
  wire        l0 = e0 ? o0 : h[0];
  wire        l1 = e1 ? o1 : h[1];
  sfc_cmd_engine #(.PROG_CYC(2000), .SECTOR_CYC(600), .BLOCK_CYC(800), .FULL_CYC(1000)) sfc_cmd_engine_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .sel_n(sel_n), .sclk(sclk), .dual_line_zero_i(l0),
    .dual_line_zero_o_q(o0), .dual_line_zero_oe_q(e0), .dual_line_one_i(l1), .dual_line_one_o_q(o1),
    .dual_line_one_oe_q(e1), .mem_rd_addr_q(ra), .mem_rd_data(rd), .mem_wr_valid(wv), .mem_wr_ready(wr),
    .mem_wr_addr(wa), .mem_wr_data(wd), .mem_erase_q(ee), .mem_erase_kind_q(ek), .mem_erase_addr_q(ea),
    .status_q(st));
  sfc_mem_model sfc_mem_model_i (.core_clk(core_clk), .rd_addr(ra), .rd_data(rd), .wr_valid(wv),
    .wr_ready(wr), .wr_addr(wa), .wr_data(wd));
  // Core clock
  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end
  // One link clock: drive on low phase, sample before rise
  task clk2(input [1:0] d); begin
    h = d; sclk = 0; repeat (10) @(negedge core_clk);
    q = {l1, l0}; sclk = 1; repeat (10) @(negedge core_clk);
  end endtask
  task tx(input [7:0] v, input integer n); integer i; begin
    for (i = 7; i > 7 - n; i--) clk2({~v[i], v[i]});
  end endtask
  task txd(input [7:0] v); integer i; begin
    for (i = 3; i >= 0; i--) clk2(v[2*i+1 -: 2]);
  end endtask
  task rxd(output [7:0] v); integer i; begin
    for (i = 3; i >= 0; i--) begin clk2(i[1:0]); v[2*i+1 -: 2] = q; end
  end endtask
  task go; begin sel_n = 0; repeat (4) @(negedge core_clk); end endtask
  task stop; begin sel_n = 1; sclk = 0; repeat (8) @(negedge core_clk); end endtask
  task cmd(input [7:0] v, input integer n); begin go; tx(v, n); stop; end endtask
  task status_read_cmd(output [7:0] v); integer i; begin
    go; tx(8'h05, 8);
    for (i = 7; i >= 0; i--) begin clk2(2'h0); v[i] = q[1]; end
    stop;
  end endtask
  task chk(input [31:0] g, input [31:0] x); begin
    num_checks++;
    if (g !== x) begin $display("[ERR] %0t got %h exp %h", $time, g, x); miscompares++; end
  end endtask
  task give_verdict; begin
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  end endtask
  task idle; integer i; begin
    for (i = 0; i < 6000 && st[0] !== 1'b0; i++) @(negedge core_clk);
    if (st[0] !== 1'b0) begin miscompares++; give_verdict; end
  end endtask
  // Erase table: opcode, kind, base
  reg [7:0]  eo [0:4] = '{8'h20, 8'hD7, 8'hD8, 8'h60, 8'hC7};
  reg [1:0]  ekx [0:4] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h3};
  reg [18:0] eax [0:4] = '{19'h12000, 19'h12000, 19'h10000, 19'h0, 19'h0};
  // Main sequence
  initial begin
    sel_n = 1; sclk = 0; h = 0; q = 0; sys_rst = 1;
    repeat (20) @(negedge core_clk);
    sys_rst = 0; repeat (4) @(negedge core_clk);
    status_read_cmd(b); chk(b, 8'h00);
    cmd(8'h06, 8); status_read_cmd(b); chk(b, 8'h02);
    cmd(8'h04, 8); status_read_cmd(b); chk(b, 8'h00);
    cmd(8'h06, 4); status_read_cmd(b); chk(b, 8'h00);
    cmd(8'h06, 8); go; tx(8'h02, 8); tx(8'h00, 8); tx(8'h12, 8); tx(8'hFE, 8);
    tx(8'hAA, 8); tx(8'h55, 8); tx(8'hC3, 8); tx(8'hFF, 3); stop;
    status_read_cmd(b); chk(b, 8'h03);
    idle; status_read_cmd(b); chk(b, 8'h00);
    chk(sfc_mem_model_i.mem[8'hFF], 8'h55); chk(sfc_mem_model_i.mem[8'h00], 8'hC3);
    chk(sfc_mem_model_i.mem[8'h01], 8'hFF);
    go; tx(8'h3B, 8); tx(8'h00, 8); tx(8'h12, 8); tx(8'hFE, 8); tx(8'h00, 8);
    rxd(b); chk(b, 8'hAA); rxd(b); chk(b, 8'h55); rxd(b); chk(b, 8'hC3); stop;
    go; tx(8'hBB, 8); txd(8'h07); txd(8'hFF); txd(8'hFF); txd(8'h00);
    rxd(b); chk(b, 8'h55); rxd(b); chk(b, 8'hC3); chk(ra, 19'h00001); stop;
    for (k = 0; k < 5; k++) begin
      cmd(8'h06, 8); go; tx(eo[k], 8);
      if (ekx[k] != 2'h3) begin tx(8'h01, 8); tx(8'h23, 8); tx(8'h45, 8); end
      stop; idle;
      chk(ek, ekx[k]); chk(ea, eax[k]); chk(ne, k + 1);
    end
    cmd(8'h06, 8); go; tx(8'h01, 8); tx(8'h10, 8); stop; status_read_cmd(b); chk(b, 8'h10);
    cmd(8'h06, 8); go; tx(8'h20, 8); tx(8'h01, 8); tx(8'h23, 8); tx(8'h45, 8); stop;
    status_read_cmd(b); chk(b, 8'h10); chk(ne, 5);
    cmd(8'h06, 8); cmd(8'h60, 8); status_read_cmd(b); chk(b, 8'h10); chk(ne, 5);
    give_verdict;
  end
endmodule // sfc_cmd_engine_test
bind sfc_cmd_engine sfc_cmd_engine_chk #(.ADDR_W(ADDR_W)) chk_i (.core_clk(core_clk), .sys_rst(sys_rst),
  .sel_n(sel_n), .dual_line_zero_oe_q(dual_line_zero_oe_q), .dual_line_one_oe_q(dual_line_one_oe_q),
  .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
  .mem_erase_q(mem_erase_q), .mem_erase_kind_q(mem_erase_kind_q), .mem_erase_addr_q(mem_erase_addr_q),
  .status_q(status_q));

/* File: test/sfc_mem_model.sv */
`timescale 1ns/1ns
module sfc_mem_model (
  input  wire        core_clk, // Core clock
  input  wire [18:0] rd_addr,  // Read address
  output reg  [7:0]  rd_data,  // Read byte
  input  wire        wr_valid, // Write offered
  output reg         wr_ready, // Write taken
  input  wire [18:0] wr_addr,  // Write address
  input  wire [7:0]  wr_data   // Write byte
);
  reg [7:0] mem [0:255];
  integer   i;
  // Array starts erased, so every program target is all ones
  initial begin
    for (i = 0; i < 256; i++) mem[i] = 8'hFF;
    wr_ready = 1'b0;
  end
  // Registered read, stalling write side every other cycle
  always @(posedge core_clk) begin
    rd_data <= mem[rd_addr[7:0]];
    wr_ready <= ~wr_ready;
    if (wr_valid && wr_ready) mem[wr_addr[7:0]] <= wr_data;
  end
endmodule // sfc_mem_model
